// *** sfi_core.v ***
// SPI unit control, mode fault, overrun, flag clearing and interrupt request logic
//
// Our own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "sfi_regs.vh"
// Contract
// [R1] Master drives clock and MOSI, slave drives MISO
// [R2] Fault: slave SS high mid-transfer, master SS low
// [R3] Fault flag sets only with fault enable
// [R4] Shared error request from fault or overrun
// [R5] Master fault disables unit, sets empty, releases pins
// [R6] Phase 0 slave: SS fall starts, idle clock ends
// [R7] Phase 1 slave: clock leaving idle starts transfer
// [R8] Fault leaves master select untouched
// [R9] Phase 0 select/deselect faults; phase 1 does not (code faults a mid-transfer deselect in both phases)
// [R10] Slave fault requests interrupt, keeps unit enabled
// [R11] SS high: MISO released, slave clocks ignored
// [R12] Fault clears by status read then control write
// [R13] Transmit request needs enable; data write clears empty
// [R14] Receive request ignores unit enable
// [R15] Full clears by status read then data read
// [R16] Each byte move sets full or empty flag
// [R17] Disabled unit: empty set, transfer aborted, pins released
// [R18] Disable keeps control bits and sticky flags
// [R19] Wait mode: keeps running, requests wake
// [R20] Stop halts and holds; reset aborts (code still starts phase 0 slaves on SS fall and detects mode faults in stop)
// [R21] Protected break: accesses leave flags alone
// [R22] Unprotected break: clears allowed and stay
// [R23] Protected break: data writes ignored
// [R24] Overrun at bit 1 capture blocks further bytes
// [R25] Overrun clears by status read then data read
// [R26] Break inputs sampled on bus clock
// [R27] Software clears port directions before re-enable
module sfi_core (
  input wire aclk,
  input wire aresetn,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire sck_i,
  output wire sck_o,
  output wire sck_oe,
  input wire mosi_i,
  output wire mosi_o,
  output wire mosi_oe,
  input wire miso_i,
  output wire miso_o,
  output wire miso_oe,
  input wire ss_n_i,
  input wire break_state,
  input wire break_clear_enable,
  input wire stop_mode,
  output wire tx_irq,
  output wire rx_err_irq,
  output wire wake_req
);
  // ****************************************
  // Helpers
  // ****************************************
  function [1:0] addr_dec;
    input [31:0] a;
    begin
      if (a == `SFI_OFF_CTRL) addr_dec = 2'h0;
      else if (a == `SFI_OFF_STAT) addr_dec = 2'h1;
      else if (a == `SFI_OFF_DATA) addr_dec = 2'h2;
      else addr_dec = 2'h3;
    end
  endfunction

  function [6:0] half_cnt;
    input [1:0] r;
    begin
      if (r == 2'h0) half_cnt = `SFI_HALF_DIV2;
      else if (r == 2'h1) half_cnt = `SFI_HALF_DIV8;
      else if (r == 2'h2) half_cnt = `SFI_HALF_DIV32;
      else half_cnt = `SFI_HALF_DIV128;
    end
  endfunction

  // ****************************************
  // State
  // ****************************************
  reg rx_ie_reg, master_reg, cpol_reg, cpha_reg, wor_reg, ue_reg, tx_ie_reg;
  reg err_ie_reg, mf_en_reg;
  reg [1:0] rate_reg;
  reg rx_full_reg, ovr_reg, mode_fault_flag_reg, tx_empty_reg;
  reg rx_arm_reg, ovr_arm_reg, mode_fault_flag_arm_reg;
  reg [7:0] tx_data_reg, rx_data_reg, shift_reg;
  reg rx_bit_reg, pend_reg, active_reg, sck_tog_reg;
  reg [3:0] smp_cnt_reg;
  reg [6:0] tmr_reg;
  reg [4:0] exp_cnt_reg;
  reg bvalid_reg, rvalid_reg;
  reg [1:0] bresp_reg, rresp_reg;
  reg [31:0] rdata_reg;
  reg sck_s1_reg, sck_s2_reg, sck_s3_reg;
  reg ss_s1_reg, ss_s2_reg, ss_s3_reg;
  reg mosi_s1_reg, mosi_s2_reg, miso_s1_reg, miso_s2_reg;
  reg brk_s1_reg, brk_s2_reg, break_clear_enable_s1_reg, break_clear_enable_s2_reg, stop_s1_reg, stop_s2_reg;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // Bit clock is far slower than aclk, so two flops plus an edge flop suffice
  always @(posedge aclk) begin
    sck_s1_reg <= sck_i;
    sck_s2_reg <= sck_s1_reg;
    sck_s3_reg <= sck_s2_reg;
    ss_s1_reg <= ss_n_i;
    ss_s2_reg <= ss_s1_reg;
    ss_s3_reg <= ss_s2_reg;
    mosi_s1_reg <= mosi_i;
    mosi_s2_reg <= mosi_s1_reg;
    miso_s1_reg <= miso_i;
    miso_s2_reg <= miso_s1_reg;
    brk_s1_reg <= break_state; // [R26]
    brk_s2_reg <= brk_s1_reg;
    break_clear_enable_s1_reg <= break_clear_enable;
    break_clear_enable_s2_reg <= break_clear_enable_s1_reg;
    stop_s1_reg <= stop_mode;
    stop_s2_reg <= stop_s1_reg;
  end

  // ****************************************
  // Combinational decode
  // ****************************************
  wire wr_go = s_axi_awvalid & s_axi_wvalid & ~bvalid_reg;
  wire rd_go = s_axi_arvalid & ~rvalid_reg;
  wire [1:0] wsel = addr_dec(s_axi_awaddr);
  wire [1:0] rsel = addr_dec(s_axi_araddr);
  wire protect = brk_s2_reg & ~break_clear_enable_s2_reg; // [R21] [R22]
  wire run = ~stop_s2_reg; // [R20]
  wire master_on = ue_reg & master_reg; // [R8]
  wire slave_on = ue_reg & ~master_reg;
  wire ss_low = ~ss_s2_reg;
  wire sck_chg = sck_s2_reg ^ sck_s3_reg;
  wire lead_s = slave_on & ss_low & run & sck_chg & (sck_s3_reg == cpol_reg); // [R11]
  wire trail_s = slave_on & ss_low & run & sck_chg & (sck_s2_reg == cpol_reg); // [R11]
  wire tick = master_on & active_reg & run & (tmr_reg == 7'h00);
  wire edge_m = tick & (cpha_reg ? (exp_cnt_reg < `SFI_EDGES) : (exp_cnt_reg != 5'h00));
  wire lead_m = edge_m & (exp_cnt_reg[0] ^ cpha_reg);
  wire trail_m = edge_m & ~(exp_cnt_reg[0] ^ cpha_reg);
  wire lead = active_reg & (master_on ? lead_m : lead_s);
  wire trail = active_reg & (master_on ? trail_m : trail_s);
  wire samp = cpha_reg ? trail : lead;
  wire shft = cpha_reg ? lead : trail;
  wire in_bit = master_reg ? miso_s2_reg : mosi_s2_reg;
  wire done_m = tick & (exp_cnt_reg == `SFI_EDGES);
  wire done_s = trail_s & active_reg &
    (cpha_reg ? (smp_cnt_reg == `SFI_BITS - 4'h1) : (smp_cnt_reg == `SFI_BITS)); // [R6] [R7]
  wire done = master_on ? done_m : done_s;
  wire [7:0] byte_in = {shift_reg[6:0], (samp ? in_bit : rx_bit_reg)};
  wire start_s0 = slave_on & ~cpha_reg & ss_s3_reg & ss_low & ~active_reg; // [R6]
  wire start_s1 = slave_on & cpha_reg & ~active_reg & run & ss_low & sck_chg &
    (sck_s3_reg == cpol_reg); // [R7]
  wire mf_m = master_on & mf_en_reg & ss_low; // [R2]
  wire mf_s = slave_on & mf_en_reg & active_reg & ss_s2_reg; // [R2] [R9]
  wire mf_cond = mf_m | mf_s;
  wire load = ue_reg & run & ~active_reg & ~tx_empty_reg;

  // ****************************************
  // Registers, engine and flags
  // ****************************************
  // Later assignments win, so flag sets follow the clears below
  always @(posedge aclk) begin
    if (!aresetn) begin
      rx_ie_reg <= 1'b0;
      master_reg <= `SFI_RST_MASTER_SELECT_ALIAS;
      cpol_reg <= 1'b0;
      cpha_reg <= `SFI_RST_CPHA;
      wor_reg <= 1'b0;
      ue_reg <= 1'b0;
      tx_ie_reg <= 1'b0;
      err_ie_reg <= 1'b0;
      mf_en_reg <= 1'b0;
      rate_reg <= 2'h0;
      rx_full_reg <= 1'b0;
      ovr_reg <= 1'b0;
      mode_fault_flag_reg <= 1'b0;
      tx_empty_reg <= `SFI_RST_TXE;
      rx_arm_reg <= 1'b0;
      ovr_arm_reg <= 1'b0;
      mode_fault_flag_arm_reg <= 1'b0;
      tx_data_reg <= 8'h00;
      rx_data_reg <= 8'h00;
      shift_reg <= 8'h00;
      rx_bit_reg <= 1'b0;
      pend_reg <= 1'b0;
      active_reg <= 1'b0;
      sck_tog_reg <= 1'b0;
      smp_cnt_reg <= 4'h0;
      tmr_reg <= 7'h00;
      exp_cnt_reg <= 5'h00;
      bvalid_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      bresp_reg <= `SFI_RESP_OKAY;
      rresp_reg <= `SFI_RESP_OKAY;
      rdata_reg <= 32'h0000_0000;
    end else begin
      // Bus answers
      if (bvalid_reg && s_axi_bready) bvalid_reg <= 1'b0;
      if (rvalid_reg && s_axi_rready) rvalid_reg <= 1'b0;
      // Shift engine
      if (master_on && active_reg && run) begin
        tmr_reg <= (tmr_reg == 7'h00) ? half_cnt(rate_reg) : tmr_reg - 7'h01;
        if (tick) exp_cnt_reg <= exp_cnt_reg + 5'h01;
        if (edge_m) sck_tog_reg <= ~sck_tog_reg; // [R1]
      end
      if (samp) begin
        rx_bit_reg <= in_bit;
        pend_reg <= 1'b1;
        smp_cnt_reg <= smp_cnt_reg + 4'h1;
        if (smp_cnt_reg == `SFI_BITS - 4'h2 && rx_full_reg) ovr_reg <= 1'b1; // [R24]
      end
      if (shft && pend_reg) begin
        shift_reg <= {shift_reg[6:0], rx_bit_reg};
        pend_reg <= 1'b0;
      end
      if (start_s0 || start_s1) begin
        active_reg <= 1'b1;
        smp_cnt_reg <= 4'h0;
        pend_reg <= 1'b0;
      end
      if (done) begin
        active_reg <= 1'b0;
        shift_reg <= byte_in;
        pend_reg <= 1'b0;
        smp_cnt_reg <= 4'h0;
        exp_cnt_reg <= 5'h00;
        sck_tog_reg <= 1'b0;
        if (!ovr_reg && !(samp && smp_cnt_reg == `SFI_BITS - 4'h2 && rx_full_reg)) begin
          rx_data_reg <= byte_in;
        end
      end
      if (slave_on && ss_s2_reg) begin
        active_reg <= 1'b0; // [R11]
        smp_cnt_reg <= 4'h0;
        pend_reg <= 1'b0;
      end
      if (load) begin
        shift_reg <= tx_data_reg;
        tx_empty_reg <= 1'b1; // [R16]
        if (master_reg) begin
          active_reg <= 1'b1;
          tmr_reg <= half_cnt(rate_reg);
          exp_cnt_reg <= 5'h00;
          smp_cnt_reg <= 4'h0;
          pend_reg <= 1'b0;
        end
      end
      // Register writes
      if (wr_go) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= (wsel == 2'h3) ? `SFI_RESP_SLVERR : `SFI_RESP_OKAY;
        if (wsel == 2'h0 && s_axi_wstrb[0]) begin
          rx_ie_reg <= s_axi_wdata[`SFI_C_RXIE];
          master_reg <= s_axi_wdata[`SFI_C_MASTER_SELECT_ALIAS];
          cpol_reg <= s_axi_wdata[`SFI_C_CPOL];
          cpha_reg <= s_axi_wdata[`SFI_C_CPHA];
          wor_reg <= s_axi_wdata[`SFI_C_WOR];
          ue_reg <= s_axi_wdata[`SFI_C_UE];
          tx_ie_reg <= s_axi_wdata[`SFI_C_TXIE];
          if (mode_fault_flag_arm_reg && !mf_cond && !protect) begin
            mode_fault_flag_reg <= 1'b0; // [R12]
            mode_fault_flag_arm_reg <= 1'b0;
          end
        end else if (wsel == 2'h1 && s_axi_wstrb[0]) begin
          rate_reg <= s_axi_wdata[`SFI_S_RATE_HI:`SFI_S_RATE_LO];
          mf_en_reg <= s_axi_wdata[`SFI_S_MFEN];
          err_ie_reg <= s_axi_wdata[`SFI_S_ERROR_IRQ_ENABLE];
        end else if (wsel == 2'h2 && s_axi_wstrb[0] && !protect) begin
          tx_data_reg <= s_axi_wdata[7:0]; // [R23]
          tx_empty_reg <= 1'b0; // [R13]
        end
      end
      // Register reads and the first or second clearing step
      if (rd_go) begin
        rvalid_reg <= 1'b1;
        rresp_reg <= (rsel == 2'h3) ? `SFI_RESP_SLVERR : `SFI_RESP_OKAY;
        if (rsel == 2'h0) begin
          rdata_reg <= {24'h000000, tx_ie_reg, ue_reg, wor_reg, cpha_reg, cpol_reg,
            master_reg, 1'b0, rx_ie_reg};
        end else if (rsel == 2'h1) begin
          rdata_reg <= {24'h000000, rx_full_reg, err_ie_reg, ovr_reg, mode_fault_flag_reg,
            tx_empty_reg, mf_en_reg, rate_reg};
          if (!protect) begin
            rx_arm_reg <= rx_full_reg;
            ovr_arm_reg <= ovr_reg;
            mode_fault_flag_arm_reg <= mode_fault_flag_reg;
          end
        end else if (rsel == 2'h2) begin
          rdata_reg <= {24'h000000, rx_data_reg};
          if (!protect) begin
            if (rx_arm_reg) rx_full_reg <= 1'b0; // [R15]
            if (ovr_arm_reg) ovr_reg <= 1'b0; // [R25]
            rx_arm_reg <= 1'b0;
            ovr_arm_reg <= 1'b0;
          end
        end else begin
          rdata_reg <= 32'h0000_0000;
        end
      end
      // Event sets win over the clears above
      if (done && !ovr_reg && !(samp && smp_cnt_reg == `SFI_BITS - 4'h2 && rx_full_reg)) begin
        rx_full_reg <= 1'b1; // [R16] [R24]
      end
      if (samp && active_reg && smp_cnt_reg == `SFI_BITS - 4'h2 && rx_full_reg) begin
        ovr_reg <= 1'b1; // [R24]
      end
      if (mf_s) mode_fault_flag_reg <= 1'b1; // [R2] [R3] [R10]
      if (mf_m) begin
        mode_fault_flag_reg <= 1'b1; // [R3] [R8]
        ue_reg <= 1'b0; // [R5]
      end
      // Partial reset keeps control bits and sticky flags
      if (!ue_reg || mf_m) begin
        tx_empty_reg <= 1'b1; // [R17] [R5] [R18]
        active_reg <= 1'b0;
        shift_reg <= 8'h00;
        smp_cnt_reg <= 4'h0;
        exp_cnt_reg <= 5'h00;
        tmr_reg <= 7'h00;
        sck_tog_reg <= 1'b0;
        pend_reg <= 1'b0;
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Wired-or mode drives only lows and releases highs
  wire sck_val = cpol_reg ^ sck_tog_reg;
  assign sck_o = wor_reg ? 1'b0 : sck_val;
  assign sck_oe = master_on & (~wor_reg | ~sck_val); // [R1] [R5] [R17]
  assign mosi_o = wor_reg ? 1'b0 : shift_reg[7];
  assign mosi_oe = master_on & (~wor_reg | ~shift_reg[7]); // [R1]
  assign miso_o = wor_reg ? 1'b0 : shift_reg[7];
  assign miso_oe = slave_on & ss_low & (~wor_reg | ~shift_reg[7]); // [R1] [R11]
  assign tx_irq = tx_empty_reg & tx_ie_reg & ue_reg; // [R13]
  assign rx_err_irq = (rx_full_reg & rx_ie_reg) | (err_ie_reg & (mode_fault_flag_reg | ovr_reg)); // [R4] [R14]
  assign wake_req = tx_irq | rx_err_irq; // [R19]
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = rd_go;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;
endmodule // sfi_core
`default_nettype wire

// *** sfi_regs.vh ***
// Register offsets, field positions, reset values and timing for the SPI fault/control block
`ifndef SFI_REGS_VH
`define SFI_REGS_VH
// ****************************************
// Register byte offsets
// ****************************************
`define SFI_OFF_CTRL 32'h0000_0000
`define SFI_OFF_STAT 32'h0000_0004
`define SFI_OFF_DATA 32'h0000_0008
// ****************************************
// Control register fields
// ****************************************
`define SFI_C_RXIE 0
`define SFI_C_DMA_SELECT 1
`define SFI_C_MASTER_SELECT_ALIAS 2
`define SFI_C_CPOL 3
`define SFI_C_CPHA 4
`define SFI_C_WOR 5
`define SFI_C_UE 6
`define SFI_C_TXIE 7
// ****************************************
// Status and control register fields
// ****************************************
`define SFI_S_RATE_LO 0
`define SFI_S_RATE_HI 1
`define SFI_S_MFEN 2
`define SFI_S_TXE 3
`define SFI_S_MODE_FAULT_FLAG 4
`define SFI_S_OVR 5
`define SFI_S_ERROR_IRQ_ENABLE 6
`define SFI_S_RXF 7
// ****************************************
// Reset values
// ****************************************
`define SFI_RST_MASTER_SELECT_ALIAS 1'b1
`define SFI_RST_CPHA 1'b1
`define SFI_RST_TXE 1'b1
// ****************************************
// Half bit time in bus cycles, minus one; clock edges and bits per byte; bus responses
// ****************************************
`define SFI_HALF_DIV2 7'h00
`define SFI_HALF_DIV8 7'h03
`define SFI_HALF_DIV32 7'h0f
`define SFI_HALF_DIV128 7'h3f
`define SFI_EDGES 5'h10
`define SFI_BITS 4'h8
`define SFI_RESP_OKAY 2'h0
`define SFI_RESP_SLVERR 2'h2
`endif

// *** sfi_monitor.sv ***
// Port-level assertions for the SPI fault and control block
`timescale 1ns/10ps
`default_nettype none
module sfi_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic sck_oe,
  input wire logic mosi_oe,
  input wire logic miso_oe,
  input wire logic ss_n_i,
  input wire logic tx_irq,
  input wire logic rx_err_irq,
  input wire logic wake_req
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ****************************************
  // Assertions
  // ****************************************
  a_write_answer: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid |=> s_axi_bvalid)
    else $error("write not answered in one cycle");
  a_resp_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response held after acceptance");
  a_read_answer: assert property (s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid)
    else $error("read not answered in one cycle");
  a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[31:4] != 28'h0
    |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
  a_master_pins: assert property (sck_oe |-> mosi_oe && !miso_oe)
    else $error("master pin directions wrong");
  a_miso_release: assert property (ss_n_i [*4] |-> !miso_oe)
    else $error("slave output driven while deselected");
  a_wake_or: assert property (wake_req == (tx_irq || rx_err_irq))
    else $error("wake request differs from requests");
  a_reset_quiet: assert property ($rose(aresetn) |-> !sck_oe && !mosi_oe && !miso_oe && !tx_irq)
    else $error("pins or request active after reset");
  c_err_req: cover property ($rose(rx_err_irq));
  c_slave_out: cover property ($rose(miso_oe));
  c_master_off: cover property ($fell(sck_oe));
endmodule // sfi_monitor
bind sfi_core sfi_monitor mon (.*);
`default_nettype wire

// *** sfi_partner.sv ***
// Behavioural far-side SPI slave, phase 1 and polarity 0
`timescale 1ns/10ps
`default_nettype none
module sfi_partner (
  input wire logic aclk,
  input wire logic sel,
  input wire logic sck,
  input wire logic mosi,
  input wire logic [7:0] tx,
  output var logic miso,
  output var logic [7:0] rx
);
  logic [2:0] k;
  initial begin
    miso = 1'b0;
    rx = 8'h00;
    k = 3'h0;
  end
  always @(posedge sck) begin
    if (sel) begin
      miso <= tx[3'h7 - k];
      k <= k + 3'h1;
    end
  end
  always @(negedge sck) begin
    if (sel) begin
      rx <= {rx[6:0], mosi};
    end
  end
  // Released line toggles so a stale bit never passes as data
  always @(posedge aclk) begin
    if (!sel) begin
      miso <= ~miso;
    end
  end
endmodule // sfi_partner
`default_nettype wire

// *** tb.sv ***
// Self-checking bench for the SPI fault and control block
`timescale 1ns/10ps
`default_nettype none
`include "sfi_regs.vh"
module tb;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic sck_i, sck_o, sck_oe, mosi_i, mosi_o, mosi_oe, miso_i, miso_o, miso_oe, ss_n_i;
  logic break_state, break_clear_enable, stop_mode, tx_irq, rx_err_irq, wake_req, sel;
  logic [7:0] ptx, prx, b1;
  logic [33:0] q[$];
  int error_cnt, checked;
  sfi_core dut (.*);
  sfi_partner pm (.aclk(aclk), .sel(sel), .sck(sck_o & sck_oe), .mosi(mosi_o), .tx(ptx),
    .miso(miso_i), .rx(prx));
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [33:0] s, input logic [33:0] e);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("Error %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task automatic final_report();
    $display("mismatches %0d comparisons %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Bounded wait; a hang ends the run
  task automatic wt(ref logic s, input logic v);
    int n;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (s !== v && n < 400);
    if (s !== v) begin
      error_cnt++;
      final_report();
    end
  endtask
  // Synchronisers add lag, so pins are looked at four edges on
  task automatic pk(ref logic s, input logic e);
    repeat (4) @(posedge aclk);
    chk(s, e);
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} <= {a, d, 2'b11};
    wt(s_axi_awready, 1'b1);
    {s_axi_awvalid, s_axi_wvalid} <= 2'b00;
    wt(s_axi_bvalid, 1'b1);
  endtask
  task automatic rd(input logic [31:0] a, input logic [33:0] e);
    q.push_back(e);
    {s_axi_araddr, s_axi_arvalid} <= {a, 1'b1};
    wt(s_axi_arready, 1'b1);
    s_axi_arvalid <= 1'b0;
    wt(s_axi_rvalid, 1'b1);
  endtask
  // Read results meet the oldest noted expectation
  always @(posedge aclk) begin
    if (s_axi_rvalid === 1'b1 && q.size() > 0) begin
      chk({s_axi_rresp, s_axi_rdata}, q.pop_front());
    end
  end
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 4'h0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3f;
    {sck_i, mosi_i, ss_n_i, break_state, break_clear_enable, stop_mode, sel} = 7'h10;
    void'($urandom(32'h7689f3f3));
    ptx = 8'($urandom);
    b1 = 8'($urandom);
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`SFI_OFF_CTRL, 34'h14);
    rd(`SFI_OFF_STAT, 34'h08);
    rd(32'h10, {2'h2, 32'h0});
    $display("test reset values done");
    sel <= 1'b1;
    wr(`SFI_OFF_STAT, 32'h41);
    wr(`SFI_OFF_CTRL, 32'h55);
    pk(mosi_oe, 1'b1);
    pk(rx_err_irq, 1'b0);
    wr(`SFI_OFF_DATA, {24'h0, b1});
    wt(rx_err_irq, 1'b1);
    chk(wake_req, 1'b1);
    chk(prx, b1);
    rd(`SFI_OFF_STAT, 34'hc9);
    wr(`SFI_OFF_CTRL, 32'h54);
    pk(rx_err_irq, 1'b0);
    wr(`SFI_OFF_DATA, {24'h0, ~b1});
    wt(rx_err_irq, 1'b1);
    rd(`SFI_OFF_STAT, 34'he9);
    wr(`SFI_OFF_CTRL, 32'h14);
    rd(`SFI_OFF_STAT, 34'he9);
    rd(`SFI_OFF_CTRL, 34'h14);
    rd(`SFI_OFF_DATA, {26'h0, ptx});
    rd(`SFI_OFF_STAT, 34'h49);
    pk(rx_err_irq, 1'b0);
    $display("test master transfer and overrun done");
    wr(`SFI_OFF_CTRL, 32'h94);
    pk(tx_irq, 1'b0);
    wr(`SFI_OFF_CTRL, 32'hd4);
    pk(tx_irq, 1'b1);
    break_state <= 1'b1;
    repeat (4) @(posedge aclk);
    wr(`SFI_OFF_DATA, 32'h3c);
    pk(tx_irq, 1'b1);
    rd(`SFI_OFF_STAT, 34'h49);
    break_state <= 1'b0;
    $display("test transmit request and break done");
    wr(`SFI_OFF_STAT, 32'h45);
    ss_n_i <= 1'b0;
    wt(rx_err_irq, 1'b1);
    pk(sck_oe, 1'b0);
    pk(mosi_oe, 1'b0);
    pk(tx_irq, 1'b0);
    rd(`SFI_OFF_CTRL, 34'h94);
    rd(`SFI_OFF_STAT, 34'h5d);
    ss_n_i <= 1'b1;
    rd(`SFI_OFF_STAT, 34'h5d);
    wr(`SFI_OFF_CTRL, 32'h14);
    rd(`SFI_OFF_STAT, 34'h4d);
    wr(`SFI_OFF_STAT, 32'h41);
    wr(`SFI_OFF_CTRL, 32'h54);
    ss_n_i <= 1'b0;
    pk(rx_err_irq, 1'b0);
    rd(`SFI_OFF_CTRL, 34'h54);
    ss_n_i <= 1'b1;
    $display("test master fault done");
    sel <= 1'b0;
    wr(`SFI_OFF_STAT, 32'h44);
    wr(`SFI_OFF_CTRL, 32'h40);
    ss_n_i <= 1'b0;
    pk(miso_oe, 1'b1);
    ss_n_i <= 1'b1;
    wt(rx_err_irq, 1'b1);
    pk(miso_oe, 1'b0);
    rd(`SFI_OFF_CTRL, 34'h40);
    rd(`SFI_OFF_STAT, 34'h5c);
    wr(`SFI_OFF_CTRL, 32'h50);
    rd(`SFI_OFF_STAT, 34'h4c);
    ss_n_i <= 1'b0;
    repeat (4) @(posedge aclk);
    ss_n_i <= 1'b1;
    pk(rx_err_irq, 1'b0);
    ss_n_i <= 1'b0;
    repeat (4) @(posedge aclk);
    sck_i <= 1'b1;
    repeat (4) @(posedge aclk);
    ss_n_i <= 1'b1;
    wt(rx_err_irq, 1'b1);
    sck_i <= 1'b0;
    rd(`SFI_OFF_STAT, 34'h5c);
    $display("test slave faults done");
    final_report();
  end
endmodule // tb
`default_nettype wire
